// file: inc/frame_pkg.sv
// Purpose: Shared constants for the serial command handler and its master
// Assumes: Byte streams already framed; one byte per valid strobe
// Notes: Check value is appended low byte first
package frame_pkg;
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_ECHO = 8'h08;
   localparam logic [7:0] FN_WRITE = 8'h10;
   localparam logic [7:0] FN_ERR_BIT = 8'h80;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam int MAX_REGS = 16;
   localparam int MAX_FRAME = 41;
   localparam logic [7:0] ERR_FUNC = 8'h01;
   localparam logic [7:0] ERR_ADDR = 8'h02;
   localparam logic [7:0] ERR_QTY = 8'h03;
   localparam logic [7:0] ECHO_LEN = 8'h08;
   localparam logic [7:0] HDR_LEN = 8'h06;
   localparam logic [7:0] WR_HDR_LEN = 8'h07;

   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte
endpackage : frame_pkg

// file: inc/frame_if.sv
// Purpose: Byte stream link between master and slave handler
// Assumes: Same clock on both ends
// Notes: eof marks the last byte of a frame
`timescale 1ns/10ps
`default_nettype none
interface frame_if;
   logic [7:0] m2s_data;
   logic m2s_valid;
   logic m2s_eof;
   logic [7:0] s2m_data;
   logic s2m_valid;
   logic s2m_eof;
   modport master (output m2s_data, output m2s_valid, output m2s_eof,
                   input s2m_data, input s2m_valid, input s2m_eof);
   modport slave (input m2s_data, input m2s_valid, input m2s_eof,
                  output s2m_data, output s2m_valid, output s2m_eof);
endinterface : frame_if
`default_nettype wire

// file: core/modbus_slave.sv
// Purpose: Slave command handler for read, echo and multi-write frames
// Assumes: Framed bytes in, one per cycle at most; response sent one
//    byte per enabled cycle
// Notes: Register storage is a small flip-flop bank
`timescale 1ns/10ps
`default_nettype none
module modbus_slave #(
   parameter logic [7:0] SLAVE_ADDR = 8'h01,
   parameter int NREGS = 32
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   frame_if.slave link,
   input wire logic commit_mode_param,
   input wire logic enter_cmd,
   input wire logic [4:0] rd_index,
   output logic [15:0] rd_value,
   output logic busy
);
   typedef enum logic [1:0] {
      S_RX = 2'b00, S_EXEC = 2'b01, S_TX = 2'b10
   } state_t;
   localparam int IW = $clog2(NREGS);

   state_t st_q, st_d;
   logic [7:0] buf_q [frame_pkg::MAX_FRAME];
   logic [7:0] buf_d [frame_pkg::MAX_FRAME];
   logic [5:0] len_q, len_d;
   logic [5:0] tx_q, tx_d;
   logic [15:0] crc_q, crc_d;
   logic [15:0] live_q [NREGS];
   logic [15:0] live_d [NREGS];
   logic [15:0] shad_q [NREGS];
   logic [15:0] shad_d [NREGS];
   logic [7:0] out_q, out_d;
   logic ov_q, ov_d, oe_q, oe_d;

   // Frame fields
   logic [7:0] f_fn;
   logic [15:0] f_start, f_qty, f_rxcrc;
   logic [16:0] f_end;
   assign f_fn = buf_q[1];
   assign f_start = {buf_q[2], buf_q[3]};
   assign f_qty = {buf_q[4], buf_q[5]};
   assign f_end = {1'b0, f_start} + {1'b0, f_qty};  // Wide: no wrap at top
   assign f_rxcrc = {buf_q[len_q - 6'd1], buf_q[len_q - 6'd2]};

   assign link.s2m_data = out_q;
   assign link.s2m_valid = ov_q;
   assign link.s2m_eof = oe_q;
   assign rd_value = live_q[rd_index[IW-1:0]];
   assign busy = (st_q != S_RX);

   always_comb begin
      logic [7:0] ob;
      logic [15:0] c2;
      logic [7:0] ecode;
      logic bad;
      logic [5:0] rlen;
      logic [5:0] k;
      logic [15:0] w;
      ob = 8'h00;
      c2 = crc_q;
      ecode = 8'h00;
      bad = 1'b0;
      rlen = 6'd0;
      k = 6'd0;
      w = 16'h0000;
      st_d = st_q;
      buf_d = buf_q;
      len_d = len_q;
      tx_d = tx_q;
      crc_d = crc_q;
      live_d = live_q;
      shad_d = shad_q;
      out_d = out_q;
      ov_d = 1'b0;
      oe_d = 1'b0;
      if (enter_cmd && commit_mode_param) begin
         live_d = shad_q;
      end
      unique case (st_q)
         S_RX: begin
            if (link.m2s_valid) begin
               if (len_q < 6'(frame_pkg::MAX_FRAME)) begin
                  buf_d[len_q] = link.m2s_data;
                  len_d = len_q + 6'd1;
               end
               if (link.m2s_eof) begin
                  st_d = S_EXEC;
               end
            end
         end
         S_EXEC: begin
            c2 = frame_pkg::CRC_INIT;
            for (int i = 0; i < frame_pkg::MAX_FRAME - 2; i++) begin
               if (6'(i) < len_q - 6'd2) begin
                  c2 = frame_pkg::crc_byte(c2, buf_q[i]);
               end
            end
            st_d = S_RX;
            len_d = 6'd0;
            if (len_q >= 6'(frame_pkg::ECHO_LEN) && c2 == f_rxcrc &&
                (buf_q[0] == SLAVE_ADDR ||
                 buf_q[0] == frame_pkg::ADDR_BCAST)) begin
               if (f_fn == frame_pkg::FN_READ) begin
                  if (f_qty == 16'h0000 ||
                      f_qty > 16'(frame_pkg::MAX_REGS)) begin
                     ecode = frame_pkg::ERR_QTY;
                  end else if (f_end > 17'(NREGS)) begin
                     ecode = frame_pkg::ERR_ADDR;
                  end
                  rlen = 6'(3) + 6'(f_qty[4:0]) * 6'd2;
                  for (int i = 0; i < 2 * frame_pkg::MAX_REGS; i++) begin
                     w = live_q[IW'(f_start + 16'(i / 2))];
                     buf_d[3 + i] = (i % 2 == 0) ? w[15:8] : w[7:0];
                  end
                  buf_d[2] = {f_qty[6:0], 1'b0};
               end else if (f_fn == frame_pkg::FN_ECHO) begin
                  rlen = 6'(frame_pkg::ECHO_LEN) - 6'd2;
               end else if (f_fn == frame_pkg::FN_WRITE) begin
                  bad = f_qty == 16'h0000 ||
                        f_qty > 16'(frame_pkg::MAX_REGS) ||
                        buf_q[6] != {f_qty[6:0], 1'b0} ||
                        len_q != 6'(frame_pkg::WR_HDR_LEN) + 6'd2 +
                                 6'(buf_q[6]);
                  if (bad) begin
                     ecode = frame_pkg::ERR_QTY;
                  end else if (f_end > 17'(NREGS)) begin
                     ecode = frame_pkg::ERR_ADDR;
                  end else begin
                     for (int i = 0; i < frame_pkg::MAX_REGS; i++) begin
                        if (16'(i) < f_qty) begin
                           k = 6'(7 + 2 * i);
                           w = {buf_q[k], buf_q[k + 6'd1]};
                           shad_d[IW'(f_start + 16'(i))] = w;
                           if (!commit_mode_param) begin
                              live_d[IW'(f_start + 16'(i))] = w;
                           end
                        end
                     end
                  end
                  rlen = 6'(frame_pkg::HDR_LEN);
               end else begin
                  ecode = frame_pkg::ERR_FUNC;
               end
               if (ecode != 8'h00) begin
                  buf_d[1] = f_fn | frame_pkg::FN_ERR_BIT;
                  buf_d[2] = ecode;
                  rlen = 6'd3;
               end
               if (buf_q[0] != frame_pkg::ADDR_BCAST) begin
                  st_d = S_TX;
                  len_d = rlen;
                  tx_d = 6'd0;
                  crc_d = frame_pkg::CRC_INIT;
               end
            end
         end
         S_TX: begin
            if (tx_q < len_q) begin
               ob = buf_q[tx_q];
               crc_d = frame_pkg::crc_byte(crc_q, ob);
            end else if (tx_q == len_q) begin
               ob = crc_q[7:0];
            end else begin
               ob = crc_q[15:8];
               oe_d = 1'b1;
               st_d = S_RX;
               len_d = 6'd0;
            end
            out_d = ob;
            ov_d = 1'b1;
            tx_d = tx_q + 6'd1;
         end
         default: st_d = S_RX;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= S_RX;
         len_q <= 6'd0;
         tx_q <= 6'd0;
         crc_q <= frame_pkg::CRC_INIT;
         out_q <= 8'h00;
         ov_q <= 1'b0;
         oe_q <= 1'b0;
         for (int i = 0; i < frame_pkg::MAX_FRAME; i++) begin
            buf_q[i] <= 8'h00;
         end
         for (int i = 0; i < NREGS; i++) begin
            live_q[i] <= 16'h0000;
            shad_q[i] <= 16'h0000;
         end
      end else if (clk_en) begin
         st_q <= st_d;
         len_q <= len_d;
         tx_q <= tx_d;
         crc_q <= crc_d;
         out_q <= out_d;
         ov_q <= ov_d;
         oe_q <= oe_d;
         buf_q <= buf_d;
         live_q <= live_d;
         shad_q <= shad_d;
      end
   end
endmodule : modbus_slave
`default_nettype wire

// file: core/modbus_master.sv
// Purpose: Master end: sends a user frame with appended check value
// Assumes: User supplies body bytes in a flop buffer via index writes
// Notes: Response bytes are passed to the user side through one register stage, one cycle later
`timescale 1ns/10ps
`default_nettype none
module modbus_master (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   frame_if.master link,
   input wire logic wr_en,
   input wire logic [5:0] wr_index,
   input wire logic [7:0] wr_byte,
   input wire logic [5:0] body_len,
   input wire logic start,
   output logic sending,
   output logic [7:0] rsp_data,
   output logic rsp_valid,
   output logic rsp_eof
);
   logic [7:0] body_q [frame_pkg::MAX_FRAME];
   logic [7:0] body_d [frame_pkg::MAX_FRAME];
   logic [5:0] idx_q, idx_d, n_q, n_d;
   logic [15:0] crc_q, crc_d;
   logic run_q, run_d;
   logic [7:0] o_q, o_d;
   logic v_q, v_d, e_q, e_d;
   logic [7:0] r_q;
   logic rv_q, re_q;

   assign link.m2s_data = o_q;
   assign link.m2s_valid = v_q;
   assign link.m2s_eof = e_q;
   assign sending = run_q;
   assign rsp_data = r_q;
   assign rsp_valid = rv_q;
   assign rsp_eof = re_q;

   // User keeps quantity and byte count consistent in the body
   always_comb begin
      body_d = body_q;
      idx_d = idx_q;
      n_d = n_q;
      crc_d = crc_q;
      run_d = run_q;
      o_d = o_q;
      v_d = 1'b0;
      e_d = 1'b0;
      if (wr_en && !run_q && wr_index < 6'(frame_pkg::MAX_FRAME)) begin
         body_d[wr_index] = wr_byte;
      end
      if (!run_q) begin
         if (start) begin
            run_d = 1'b1;
            idx_d = 6'd0;
            n_d = body_len;
            crc_d = frame_pkg::CRC_INIT;
         end
      end else begin
         v_d = 1'b1;
         if (idx_q < n_q) begin
            o_d = body_q[idx_q];
            crc_d = frame_pkg::crc_byte(crc_q, body_q[idx_q]);
         end else if (idx_q == n_q) begin
            o_d = crc_q[7:0];
         end else begin
            o_d = crc_q[15:8];
            e_d = 1'b1;
            run_d = 1'b0;
         end
         idx_d = idx_q + 6'd1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < frame_pkg::MAX_FRAME; i++) begin
            body_q[i] <= 8'h00;
         end
         idx_q <= 6'd0;
         n_q <= 6'd0;
         crc_q <= frame_pkg::CRC_INIT;
         run_q <= 1'b0;
         o_q <= 8'h00;
         v_q <= 1'b0;
         e_q <= 1'b0;
         r_q <= 8'h00;
         rv_q <= 1'b0;
         re_q <= 1'b0;
      end else if (clk_en) begin
         body_q <= body_d;
         idx_q <= idx_d;
         n_q <= n_d;
         crc_q <= crc_d;
         run_q <= run_d;
         o_q <= o_d;
         v_q <= v_d;
         e_q <= e_d;
         r_q <= link.s2m_data;
         rv_q <= link.s2m_valid;
         re_q <= link.s2m_eof;
      end
   end
endmodule : modbus_master
`default_nettype wire

// file: tb/modbus_slave_function_handler_monitor.sv
// Purpose: Wire checks on the reply stream of the command handler
// Assumes: Both ends share sys_clk; one byte per valid strobe
// Notes: Reply check value is tracked by a running residue
`timescale 1ns/10ps
`default_nettype none
module modbus_slave_function_handler_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] m2s_data,
   input wire logic m2s_valid,
   input wire logic m2s_eof,
   input wire logic [7:0] s2m_data,
   input wire logic s2m_valid,
   input wire logic s2m_eof
);
   logic [15:0] crc_q, crc_d, crc_now;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Residue over a whole frame with its check appended is zero
   always_comb begin
      crc_now = crc_q;
      if (s2m_valid) begin
         crc_now = crc_q ^ {8'h00, s2m_data};
         for (int i = 0; i < 8; i++) begin
            crc_now = crc_now[0] ? (crc_now >> 1) ^ 16'hA001 : crc_now >> 1;
         end
      end
      crc_d = (s2m_valid && s2m_eof) ? 16'hFFFF : crc_now;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         crc_q <= 16'hFFFF;
      end else begin
         crc_q <= crc_d;
      end
   end
   a_reply_check_ok: assert property (
      s2m_valid && s2m_eof |-> crc_now == 16'h0000)
      else $error("reply check value wrong");
   a_no_early_reply: assert property (
      m2s_valid && m2s_eof |-> !s2m_valid ##1 !s2m_valid)
      else $error("reply before frame was checked");
   a_no_bcast_reply: assert property (
      $rose(s2m_valid) |-> s2m_data != 8'h00)
      else $error("reply to broadcast");
   a_exc_length: assert property (
      $rose(s2m_valid) ##1 s2m_data[7] |-> !s2m_eof [*3] ##1 s2m_eof)
      else $error("exception reply length wrong");
   a_exc_code: assert property (
      $rose(s2m_valid) ##1 s2m_data[7]
      |=> s2m_data inside {8'h01, 8'h02, 8'h03})
      else $error("exception code out of set");
   a_write_len: assert property (
      $rose(s2m_valid) ##1 s2m_data == 8'h10 |-> ##6 s2m_eof)
      else $error("write reply length wrong");
   a_echo_len: assert property (
      $rose(s2m_valid) ##1 s2m_data == 8'h08 |-> ##6 s2m_eof)
      else $error("echo reply length wrong");
   a_read_count: assert property (
      $rose(s2m_valid) ##1 s2m_data == 8'h03
      |=> !s2m_data[0] && s2m_data != 8'h00 && s2m_data <= 8'h20)
      else $error("read byte count wrong");
   a_back_to_back: assert property (
      s2m_valid && !s2m_eof |=> s2m_valid)
      else $error("gap inside reply");
endmodule : modbus_slave_function_handler_monitor
`default_nettype wire

// file: tb/modbus_slave_function_handler_test.sv
// Purpose: Frame-level tests of the handler driven through the master
// Assumes: Master appends the check value; clk_en held high
// Notes: Expected replies get their check value appended here
`timescale 1ns/10ps
`default_nettype none
module modbus_slave_function_handler_test;
   typedef logic [7:0] bq_t[$];
   logic sys_clk, rst, wr_en, start, commit_mode_param, enter_cmd;
   logic sending, rsp_valid, rsp_eof, busy;
   logic [5:0] wr_index, body_len;
   logic [7:0] wr_byte, rsp_data;
   logic [4:0] rd_index;
   logic [15:0] rd_value;
   logic [15:0] mdl [32];
   int n_fail, checks;
   bq_t f, e;
   frame_if link();
   modbus_slave modbus_slave_inst (.sys_clk(sys_clk), .rst(rst),
      .clk_en(1'b1), .link(link), .commit_mode_param(commit_mode_param),
      .enter_cmd(enter_cmd), .rd_index(rd_index), .rd_value(rd_value),
      .busy(busy));
   modbus_master modbus_master_inst (.sys_clk(sys_clk), .rst(rst),
      .clk_en(1'b1), .link(link), .wr_en(wr_en), .wr_index(wr_index),
      .wr_byte(wr_byte), .body_len(body_len), .start(start),
      .sending(sending), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
      .rsp_eof(rsp_eof));
   modbus_slave_function_handler_monitor mon_inst (.sys_clk(sys_clk),
      .rst(rst), .m2s_data(link.m2s_data), .m2s_valid(link.m2s_valid),
      .m2s_eof(link.m2s_eof), .s2m_data(link.s2m_data),
      .s2m_valid(link.s2m_valid), .s2m_eof(link.s2m_eof));
   function automatic logic [15:0] crc16(input bq_t q);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction : crc16
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic run(input bq_t fr, input bq_t ex);
      bq_t got;
      logic [15:0] c;
      c = crc16(ex);
      if (ex.size() > 0) begin
         ex.push_back(c[7:0]);
         ex.push_back(c[15:8]);
      end
      foreach (fr[i]) begin
         @(posedge sys_clk);
         wr_en <= 1'b1;
         wr_index <= 6'(i);
         wr_byte <= fr[i];
      end
      @(posedge sys_clk);
      wr_en <= 1'b0;
      body_len <= 6'(fr.size());
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      // Capped: a broadcast never brings an end marker
      for (int k = 0; k < 120; k++) begin
         @(negedge sys_clk);
         if (k == 0) cmp(16'(sending), 16'h0001);
         if (rsp_valid === 1'b1 && got.size() == 0) begin
            cmp(16'(busy), 16'h0001);
         end
         if (rsp_valid === 1'b1) got.push_back(rsp_data);
         if (rsp_eof === 1'b1) break;
      end
      cmp(16'(got.size()), 16'(ex.size()));
      foreach (ex[i]) cmp({8'h00, got[i]}, {8'h00, ex[i]});
      cmp({14'h0000, busy, sending}, 16'h0000);
   endtask : run
   task automatic peek(input logic [4:0] idx, input logic [15:0] exp);
      @(posedge sys_clk);
      rd_index <= idx;
      @(negedge sys_clk);
      cmp(rd_value, exp);
      @(posedge sys_clk);
   endtask : peek
   task automatic close_out;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Eleven frames of at most 170 cycles each fit well inside this span
   initial begin
      repeat (10000) @(posedge sys_clk);
      n_fail++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      wr_en = 1'b0;
      wr_index = 6'h00;
      wr_byte = 8'h00;
      body_len = 6'h00;
      start = 1'b0;
      commit_mode_param = 1'b0;
      enter_cmd = 1'b0;
      rd_index = 5'h00;
      foreach (mdl[i]) mdl[i] = 16'h0000;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      f = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01,
         8'h17, 8'h70};
      run(f, '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02});
      mdl[1] = 16'h0001;
      mdl[2] = 16'h1770;
      peek(5'h01, mdl[1]);
      peek(5'h02, mdl[2]);
      f = '{8'h01, 8'h03, 8'h00, 8'h01, 8'h00, 8'h02};
      run(f, '{8'h01, 8'h03, 8'h04, 8'h00, 8'h01, 8'h17, 8'h70});
      f = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37};
      run(f, f);
      f = '{8'h01, 8'h08, 8'hFF, 8'h00, 8'h00, 8'hFF};
      run(f, f);
      f = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11};
      run(f, '{8'h01, 8'h83, 8'h03});
      f = '{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
      run(f, '{8'h01, 8'h85, 8'h01});
      f = '{8'h01, 8'h10, 8'h00, 8'h1F, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00,
         8'h00, 8'h00};
      run(f, '{8'h01, 8'h90, 8'h02});
      // Byte count not twice the quantity: refused, nothing written
      f = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01,
         8'h17, 8'h70};
      run(f, '{8'h01, 8'h90, 8'h03});
      f = '{8'h00, 8'h10, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02, 8'hBE, 8'hEF};
      e.delete();
      run(f, e);
      mdl[3] = 16'hBEEF;
      peek(5'h03, mdl[3]);
      commit_mode_param <= 1'b1;
      f = '{8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
      run(f, '{8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01});
      peek(5'h04, 16'h0000);
      enter_cmd <= 1'b1;
      @(posedge sys_clk);
      enter_cmd <= 1'b0;
      mdl[4] = 16'h1234;
      peek(5'h04, mdl[4]);
      commit_mode_param <= 1'b0;
      // Largest read allowed: sixteen words
      e = '{8'h01, 8'h03, 8'h20};
      for (int r = 0; r < 16; r++) begin
         e.push_back(mdl[r][15:8]);
         e.push_back(mdl[r][7:0]);
      end
      run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h10}, e);
      close_out();
   end
endmodule : modbus_slave_function_handler_test
`default_nettype wire
